//--- itt_pkg.sv
// Purpose: shared types and constants for instruction cycle timing
// Assumes: one system clock, instruction class presented by fetch stage
// Notes: also holds the external-data write steering module
package itt_pkg;

  // instruction length in bytes
  localparam logic [1:0] LEN_1 = 2'h1;
  localparam logic [1:0] LEN_2 = 2'h2;
  localparam logic [1:0] LEN_3 = 2'h3;

  // execution time in system clock cycles
  localparam logic [3:0] CYC_1 = 4'h1;
  localparam logic [3:0] CYC_2 = 4'h2;
  localparam logic [3:0] CYC_3 = 4'h3;
  localparam logic [3:0] CYC_4 = 4'h4;

  // cycles saved by a conditional branch that falls through
  localparam logic [3:0] BR_FALL_SAVE = 4'h1;

  // idle value of the cycle counter
  localparam logic [3:0] CNT_IDLE = 4'h0;

  // widths of the on-chip data path
  localparam int XADDR_W = 16;
  localparam int XDATA_W = 8;

  // instruction families
  typedef enum logic [3:0] {
    C_ARITH,
    C_INCDEC,
    C_LOGIC,
    C_ACC_UNARY,
    C_MOVE,
    C_DATA_POINTER_LOAD,
    C_CODE_MOVE,
    C_XMOVE_RD,
    C_XMOVE_WR,
    C_PUSH,
    C_POP,
    C_XCH,
    C_LOW_NIBBLE_EXCHANGE,
    C_BRANCH,
    C_OTHER
  } itt_class_t;

  // operand forms; pairs are source then destination
  typedef enum logic [3:0] {
    M_ACC,
    M_REG,
    M_DIR,
    M_IND,
    M_IMM,
    M_DATA_POINTER,
    M_DIR_DIR,
    M_IMM_DIR,
    M_ACC_DIR,
    M_ACC_IND,
    M_DIR_IND,
    M_IMM_IND,
    M_IND_DIR,
    M_PC
  } itt_mode_t;

  // one decoded instruction from the fetch stage
  typedef struct packed {
    itt_class_t cls;
    itt_mode_t mode;
  } itt_instr_t;

  // length and time of one instruction
  typedef struct packed {
    logic legal;
    logic [1:0] bytes;
    logic [3:0] cycles;
  } itt_timing_t;

  // one external-data access
  typedef struct packed {
    logic [XADDR_W-1:0] addr;
    logic [XDATA_W-1:0] data;
  } itt_xreq_t;

endpackage

`timescale 1ns/1ps

// steers external-data accesses to on-chip ram or program flash
module itt_route
(
  // clock and reset
  input wire logic sys_clk,
  input wire logic rst_n,
  // request side
  input wire logic wr_req,
  input wire logic rd_req,
  input wire itt_pkg::itt_xreq_t req,
  input wire logic prog_store_wr_en,
  // on-chip storage side
  output logic external_ram_wr,
  output logic external_ram_rd,
  output logic flash_wr,
  output itt_pkg::itt_xreq_t mem_req
);

  // write goes to flash only while the store enable is set
  always_ff @(posedge sys_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      external_ram_wr <= 1'b0;
      flash_wr <= 1'b0;
      external_ram_rd <= 1'b0;
    end
    else
    begin
      flash_wr <= wr_req && prog_store_wr_en;
      external_ram_wr <= wr_req && !prog_store_wr_en;
      external_ram_rd <= rd_req && !wr_req;
    end
  end

  // address and data held with the strobe
  always_ff @(posedge sys_clk or negedge rst_n)
  begin
    if (!rst_n)
      mem_req <= '0;
    else if (wr_req || rd_req)
      mem_req <= req;
  end

endmodule

//--- itt_core.sv
// Purpose: instruction length and cycle-count sequencer for an 8-bit core
// Assumes: fetch stage presents a decoded class and operand form
// Notes: counts whole system clocks; no off-chip memory path exists
`timescale 1ns/1ps

// Summary of operation
// - external-data writes reach on-chip ram or rewritable program flash
// - no off-chip data or program memory; accesses stay on chip
// - one-cycle register arithmetic; inc/dec of acc, register, pointer
// - indirect arithmetic and indirect inc/dec: one byte, two cycles
// - direct or immediate arithmetic, direct inc/dec: two bytes, two
// - logic ops: register 1, others 2, immediate to direct 3
// - clear, complement, rotate, swap accumulator: one byte, one cycle
// - acc/register moves 1; direct or immediate 2; direct or immediate to direct 3
// - indirect moves take two cycles
// - loading the data pointer: three bytes, three cycles
// - code-byte read relative pointer or counter: one byte, three cycles
// - external-data reads and writes: one byte, three cycles
// - push and pop of a direct byte: two bytes, two cycles
// - exchange with register 1 cycle; direct, indirect, low nibble 2
// - all timing counted in system clocks, no machine cycles
// - untaken conditional branch finishes one cycle sooner than taken
// - writes go to flash only while store enable bit is set
module itt_core
(
  // clock and reset
  input wire logic sys_clk,
  input wire logic resetn,
  // instruction issue
  input wire logic instr_valid,
  input wire itt_pkg::itt_instr_t instr,
  input wire logic branch_taken,
  // instruction status
  output logic instr_ready,
  output logic instr_busy,
  output logic instr_done,
  output logic [1:0] instr_len,
  output logic [3:0] instr_cycles,
  output logic instr_illegal,
  // external-data requests
  input wire logic xd_wr_req,
  input wire logic xd_rd_req,
  input wire itt_pkg::itt_xreq_t xd_req,
  input wire logic prog_store_wr_en,
  // on-chip storage
  output logic external_ram_wr,
  output logic external_ram_rd,
  output logic flash_wr,
  output itt_pkg::itt_xreq_t mem_req
);

  // reset release
  logic rst_meta_r;
  logic rst_sync_r;
  // cycle count
  logic [3:0] cnt_r;
  logic [3:0] cnt_nxt;
  logic accept;
  // decoded timing
  itt_pkg::itt_timing_t tim;
  logic [3:0] run_cycles;

  // build a timing record
  function automatic itt_pkg::itt_timing_t mk(
    input logic [1:0] b,
    input logic [3:0] c
  );
    itt_pkg::itt_timing_t t;
    t.legal = 1'b1;
    t.bytes = b;
    t.cycles = c;
    return t;
  endfunction

  // length and cycles for each class and operand form
  function automatic itt_pkg::itt_timing_t timing_of(
    input itt_pkg::itt_instr_t i
  );
    itt_pkg::itt_timing_t t;
    t = '0;
    case (i.cls)
      // accumulator arithmetic, with or without carry or borrow
      itt_pkg::C_ARITH:
        case (i.mode)
          itt_pkg::M_REG:
            t = mk(itt_pkg::LEN_1, itt_pkg::CYC_1);
          itt_pkg::M_IND:
            t = mk(itt_pkg::LEN_1, itt_pkg::CYC_2);
          itt_pkg::M_DIR,
          itt_pkg::M_IMM:
            t = mk(itt_pkg::LEN_2, itt_pkg::CYC_2);
          default:
            t = '0;
        endcase
      // increment and decrement
      itt_pkg::C_INCDEC:
        case (i.mode)
          itt_pkg::M_ACC,
          itt_pkg::M_REG,
          itt_pkg::M_DATA_POINTER:
            t = mk(itt_pkg::LEN_1, itt_pkg::CYC_1);
          itt_pkg::M_IND:
            t = mk(itt_pkg::LEN_1, itt_pkg::CYC_2);
          itt_pkg::M_DIR:
            t = mk(itt_pkg::LEN_2, itt_pkg::CYC_2);
          default:
            t = '0;
        endcase
      // and, or, exclusive or
      itt_pkg::C_LOGIC:
        case (i.mode)
          itt_pkg::M_REG:
            t = mk(itt_pkg::LEN_1, itt_pkg::CYC_1);
          itt_pkg::M_IND:
            t = mk(itt_pkg::LEN_1, itt_pkg::CYC_2);
          itt_pkg::M_DIR,
          itt_pkg::M_IMM,
          itt_pkg::M_ACC_DIR:
            t = mk(itt_pkg::LEN_2, itt_pkg::CYC_2);
          itt_pkg::M_IMM_DIR:
            t = mk(itt_pkg::LEN_3, itt_pkg::CYC_3);
          default:
            t = '0;
        endcase
      // single-operand accumulator work
      itt_pkg::C_ACC_UNARY:
        if (i.mode == itt_pkg::M_ACC)
          t = mk(itt_pkg::LEN_1, itt_pkg::CYC_1);
      // internal moves
      itt_pkg::C_MOVE:
        case (i.mode)
          itt_pkg::M_REG:
            t = mk(itt_pkg::LEN_1, itt_pkg::CYC_1);
          itt_pkg::M_DIR,
          itt_pkg::M_IMM,
          itt_pkg::M_ACC_DIR:
            t = mk(itt_pkg::LEN_2, itt_pkg::CYC_2);
          itt_pkg::M_DIR_DIR,
          itt_pkg::M_IMM_DIR:
            t = mk(itt_pkg::LEN_3, itt_pkg::CYC_3);
          itt_pkg::M_IND,
          itt_pkg::M_ACC_IND:
            t = mk(itt_pkg::LEN_1, itt_pkg::CYC_2);
          itt_pkg::M_DIR_IND,
          itt_pkg::M_IMM_IND,
          itt_pkg::M_IND_DIR:
            t = mk(itt_pkg::LEN_2, itt_pkg::CYC_2);
          default:
            t = '0;
        endcase
      // sixteen-bit pointer load
      itt_pkg::C_DATA_POINTER_LOAD:
        if (i.mode == itt_pkg::M_IMM)
          t = mk(itt_pkg::LEN_3, itt_pkg::CYC_3);
      // code-byte read into the accumulator
      itt_pkg::C_CODE_MOVE:
        if (i.mode == itt_pkg::M_DATA_POINTER || i.mode == itt_pkg::M_PC)
          t = mk(itt_pkg::LEN_1, itt_pkg::CYC_3);
      // external-data moves, short or long address
      itt_pkg::C_XMOVE_RD,
      itt_pkg::C_XMOVE_WR:
        if (i.mode == itt_pkg::M_IND || i.mode == itt_pkg::M_DATA_POINTER)
          t = mk(itt_pkg::LEN_1, itt_pkg::CYC_3);
      // stack traffic
      itt_pkg::C_PUSH,
      itt_pkg::C_POP:
        if (i.mode == itt_pkg::M_DIR)
          t = mk(itt_pkg::LEN_2, itt_pkg::CYC_2);
      // whole-byte exchange
      itt_pkg::C_XCH:
        case (i.mode)
          itt_pkg::M_REG:
            t = mk(itt_pkg::LEN_1, itt_pkg::CYC_1);
          itt_pkg::M_DIR:
            t = mk(itt_pkg::LEN_2, itt_pkg::CYC_2);
          itt_pkg::M_IND:
            t = mk(itt_pkg::LEN_1, itt_pkg::CYC_2);
          default:
            t = '0;
        endcase
      // low nibble exchange
      itt_pkg::C_LOW_NIBBLE_EXCHANGE:
        if (i.mode == itt_pkg::M_IND)
          t = mk(itt_pkg::LEN_1, itt_pkg::CYC_2);
      // conditional branches, listed at their taken time
      itt_pkg::C_BRANCH:
        case (i.mode)
          // short relative form
          itt_pkg::M_REG:
            t = mk(itt_pkg::LEN_2, itt_pkg::CYC_3);
          // bit or compare form
          itt_pkg::M_DIR:
            t = mk(itt_pkg::LEN_3, itt_pkg::CYC_4);
          default:
            t = '0;
        endcase
      // anything else has no entry and is flagged illegal
      default:
        t = '0;
    endcase
    return t;
  endfunction

  // reset released through two flip-flops
  // so the release never lands mid-cycle inside the counter logic
  always_ff @(posedge sys_clk or negedge resetn)
  begin
    if (!resetn)
    begin
      rst_meta_r <= 1'b0;
      rst_sync_r <= 1'b0;
    end
    else
    begin
      rst_meta_r <= 1'b1;
      rst_sync_r <= rst_meta_r;
    end
  end

  // decode of the offered instruction; the untaken saving applies to
  // legal branches only, so an unknown form never wraps the count
  always_comb
  begin
    tim = timing_of(instr);
    run_cycles = tim.cycles;
    if (tim.legal && instr.cls == itt_pkg::C_BRANCH && !branch_taken)
      run_cycles = tim.cycles - itt_pkg::BR_FALL_SAVE;
  end

  // issue taken while the counter is idle; ready loads with the counter,
  // so an offer made while ready is seen high is always taken
  assign accept = instr_valid && (cnt_r == itt_pkg::CNT_IDLE);

  // next counter value, one step per system clock
  always_comb
  begin
    cnt_nxt = cnt_r;
    if (accept && tim.legal)
      cnt_nxt = run_cycles;
    else if (cnt_r != itt_pkg::CNT_IDLE)
      cnt_nxt = cnt_r - itt_pkg::CYC_1;
  end

  // cycle counter
  always_ff @(posedge sys_clk or negedge rst_sync_r)
  begin
    if (!rst_sync_r)
      cnt_r <= itt_pkg::CNT_IDLE;
    else
      cnt_r <= cnt_nxt;
  end

  // busy, done and ready flags from the next count, so they line up
  // with the counter; done marks the last cycle of an instruction
  always_ff @(posedge sys_clk or negedge rst_sync_r)
  begin
    if (!rst_sync_r)
    begin
      instr_busy <= 1'b0;
      instr_done <= 1'b0;
      instr_ready <= 1'b0;
    end
    else
    begin
      instr_busy <= cnt_nxt != itt_pkg::CNT_IDLE;
      instr_done <= cnt_nxt == itt_pkg::CYC_1;
      instr_ready <= cnt_nxt == itt_pkg::CNT_IDLE;
    end
  end

  // length, time and legality of the last accepted instruction
  // held until the next accept so the fetch stage may read it late
  always_ff @(posedge sys_clk or negedge rst_sync_r)
  begin
    if (!rst_sync_r)
    begin
      instr_len <= 2'h0;
      instr_cycles <= 4'h0;
      instr_illegal <= 1'b0;
    end
    else if (accept)
    begin
      instr_len <= tim.bytes;
      instr_cycles <= run_cycles;
      instr_illegal <= !tim.legal;
    end
  end

  // external-data steering to on-chip storage only; there is no
  // port toward off-chip memory at all
  itt_route u_route
  (
    .sys_clk(sys_clk),
    .rst_n(rst_sync_r),
    .wr_req(xd_wr_req),
    .rd_req(xd_rd_req),
    .req(xd_req),
    .prog_store_wr_en(prog_store_wr_en),
    .external_ram_wr(external_ram_wr),
    .external_ram_rd(external_ram_rd),
    .flash_wr(flash_wr),
    .mem_req(mem_req)
  );

endmodule

//--- itt_core_chk_asserts.sv
// Purpose: timing and steering checks on the itt_core ports
// Assumes: one clock, outputs registered
// Notes: bound from the bench top file
`timescale 1ns/1ps
module itt_core_chk
(
  // clock and reset
  input wire logic sys_clk,
  input wire logic resetn,
  // instruction side
  input wire logic instr_valid,
  input wire itt_pkg::itt_instr_t instr,
  input wire logic branch_taken,
  input wire logic instr_ready,
  input wire logic instr_busy,
  input wire logic instr_done,
  input wire logic [3:0] instr_cycles,
  // external-data side
  input wire logic xd_wr_req,
  input wire logic xd_rd_req,
  input wire itt_pkg::itt_xreq_t xd_req,
  input wire logic prog_store_wr_en,
  input wire logic external_ram_wr,
  input wire logic external_ram_rd,
  input wire logic flash_wr,
  input wire itt_pkg::itt_xreq_t mem_req
);
  default clocking cb @(posedge sys_clk);
  endclocking
  default disable iff (!resetn);

  // write target follows the store enable; reads go to ram, requests captured
  chk_flash_steer: assert property (
    xd_wr_req && prog_store_wr_en |=> flash_wr && !external_ram_wr)
    else $error("write not sent to flash");
  chk_ram_steer: assert property (
    xd_wr_req && !prog_store_wr_en |=> external_ram_wr && !flash_wr)
    else $error("write not sent to ram");
  chk_read_onchip: assert property (
    xd_rd_req && !xd_wr_req |=> external_ram_rd && !flash_wr)
    else $error("read not sent to ram");
  chk_read_refused: assert property (
    xd_rd_req && xd_wr_req |=> !external_ram_rd)
    else $error("read beside write not refused");
  chk_req_capture: assert property (
    xd_wr_req || xd_rd_req |=> mem_req == $past(xd_req))
    else $error("request not captured");
  // done falls in the cycle given by the count
  chk_one_cycle: assert property (
    $rose(instr_busy) && instr_cycles == 4'h1 |-> instr_done)
    else $error("one-cycle op late");
  chk_two_cycle: assert property (
    $rose(instr_busy) && instr_cycles == 4'h2 |-> !instr_done ##1 instr_done)
    else $error("two-cycle op wrong");
  chk_three_cycle: assert property (
    $rose(instr_busy) && instr_cycles == 4'h3
    |-> !instr_done [*2] ##1 instr_done)
    else $error("three-cycle op wrong");
  chk_branch_save: assert property (
    instr_ready && instr_valid && instr.cls == itt_pkg::C_BRANCH
    && instr.mode == itt_pkg::M_REG
    |=> instr_cycles == ($past(branch_taken) ? 4'h3 : 4'h2))
    else $error("branch count wrong");
  chk_done_idle: assert property (
    instr_done |=> !instr_busy && instr_ready)
    else $error("not idle after done");
endmodule

//--- itt_store.sv
// Purpose: on-chip ram and program flash behind itt_core
// Assumes: one-cycle write strobes with mem_req held
// Notes: keeps written bytes for the bench to read back
`timescale 1ns/1ps
module itt_store
(
  // clock
  input wire logic sys_clk,
  // write strobes and request
  input wire logic external_ram_wr,
  input wire logic flash_wr,
  input wire itt_pkg::itt_xreq_t mem_req
);
  logic [7:0] ram_q [int];
  logic [7:0] flash_q [int];
  // store each write in its own on-chip array
  always @(posedge sys_clk)
  begin
    if (external_ram_wr)
      ram_q[int'(mem_req.addr)] = mem_req.data;
    if (flash_wr)
      flash_q[int'(mem_req.addr)] = mem_req.data;
  end
endmodule

//--- tb_top.sv
// Purpose: self-checking bench for itt_core
// Assumes: 25 MHz clock, inputs driven on the falling edge
// Notes: checker bound after the module
`timescale 1ns/1ps
module tb_top;
  logic sys_clk = 1'b0;
  logic resetn = 1'b0;
  logic instr_valid = 1'b0;
  itt_pkg::itt_instr_t instr = '0;
  logic branch_taken = 1'b0;
  logic xd_wr_req = 1'b0;
  logic xd_rd_req = 1'b0;
  itt_pkg::itt_xreq_t xd_req = '0;
  logic prog_store_wr_en = 1'b0;
  logic instr_ready, instr_busy, instr_done, instr_illegal;
  logic external_ram_wr, external_ram_rd, flash_wr;
  logic [1:0] instr_len;
  logic [3:0] instr_cycles;
  itt_pkg::itt_xreq_t mem_req;
  int err_count = 0;
  int n_tests = 0;

  // 40 ns clock
  always #20 sys_clk = ~sys_clk;

  itt_core dut (.sys_clk, .resetn, .instr_valid, .instr, .branch_taken,
    .instr_ready, .instr_busy, .instr_done, .instr_len, .instr_cycles,
    .instr_illegal, .xd_wr_req, .xd_rd_req, .xd_req, .prog_store_wr_en,
    .external_ram_wr, .external_ram_rd, .flash_wr, .mem_req);
  itt_store store (.sys_clk, .external_ram_wr, .flash_wr, .mem_req);

  task automatic summarize;
    if (err_count == 0 && n_tests > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask

  task automatic check(input string nm, input logic [23:0] got,
    input logic [23:0] exp);
    n_tests++;
    if (got !== exp)
    begin
      err_count++;
      $display("MISMATCH %s exp %h got %h", nm, exp, got);
    end
  endtask

  // wait for ready, offer one instruction, count cycles up to done
  task automatic run(input itt_pkg::itt_class_t c,
    input itt_pkg::itt_mode_t m, input logic tk,
    input logic [1:0] l, input logic [3:0] n);
    int k;
    k = 0;
    while (instr_ready !== 1'b1 && k < 20)
    begin
      @(negedge sys_clk);
      k++;
    end
    instr = '{cls: c, mode: m};
    branch_taken = tk;
    instr_valid = 1'b1;
    @(negedge sys_clk);
    instr_valid = 1'b0;
    check("busy", 24'(instr_busy), 24'(l != 0));
    k = 1;
    while (instr_done !== 1'b1 && l != 0 && k < 9)
    begin
      @(negedge sys_clk);
      k++;
    end
    check("len", 24'(instr_len), 24'(l));
    check("illegal", 24'(instr_illegal), 24'(l == 0));
    if (l != 0)
    begin
      check("cycles", 24'(instr_cycles), 24'(n));
      check("done", 24'(k), 24'(n));
    end
  endtask

  task automatic t_arith;
    run(itt_pkg::C_ARITH, itt_pkg::M_REG, 0, 1, 1);
    run(itt_pkg::C_INCDEC, itt_pkg::M_DATA_POINTER, 0, 1, 1);
    run(itt_pkg::C_INCDEC, itt_pkg::M_ACC, 0, 1, 1);
    run(itt_pkg::C_INCDEC, itt_pkg::M_REG, 0, 1, 1);
    run(itt_pkg::C_INCDEC, itt_pkg::M_IND, 0, 1, 2);
    run(itt_pkg::C_ARITH, itt_pkg::M_IND, 0, 1, 2);
    run(itt_pkg::C_ARITH, itt_pkg::M_IMM, 0, 2, 2);
    run(itt_pkg::C_ARITH, itt_pkg::M_DIR, 0, 2, 2);
    run(itt_pkg::C_INCDEC, itt_pkg::M_DIR, 0, 2, 2);
  endtask

  task automatic t_logic;
    run(itt_pkg::C_LOGIC, itt_pkg::M_REG, 0, 1, 1);
    run(itt_pkg::C_LOGIC, itt_pkg::M_IND, 0, 1, 2);
    run(itt_pkg::C_LOGIC, itt_pkg::M_DIR, 0, 2, 2);
    run(itt_pkg::C_LOGIC, itt_pkg::M_IMM, 0, 2, 2);
    run(itt_pkg::C_LOGIC, itt_pkg::M_ACC_DIR, 0, 2, 2);
    run(itt_pkg::C_LOGIC, itt_pkg::M_IMM_DIR, 0, 3, 3);
    run(itt_pkg::C_ACC_UNARY, itt_pkg::M_ACC, 0, 1, 1);
    run(itt_pkg::C_ACC_UNARY, itt_pkg::M_REG, 0, 0, 0);
  endtask

  task automatic t_move;
    run(itt_pkg::C_MOVE, itt_pkg::M_REG, 0, 1, 1);
    run(itt_pkg::C_MOVE, itt_pkg::M_DIR, 0, 2, 2);
    run(itt_pkg::C_MOVE, itt_pkg::M_ACC_DIR, 0, 2, 2);
    run(itt_pkg::C_MOVE, itt_pkg::M_DIR_DIR, 0, 3, 3);
    run(itt_pkg::C_MOVE, itt_pkg::M_IMM_DIR, 0, 3, 3);
    run(itt_pkg::C_MOVE, itt_pkg::M_IMM, 0, 2, 2);
    run(itt_pkg::C_MOVE, itt_pkg::M_ACC_IND, 0, 1, 2);
    run(itt_pkg::C_MOVE, itt_pkg::M_IND, 0, 1, 2);
    run(itt_pkg::C_MOVE, itt_pkg::M_DIR_IND, 0, 2, 2);
    run(itt_pkg::C_MOVE, itt_pkg::M_IMM_IND, 0, 2, 2);
    run(itt_pkg::C_MOVE, itt_pkg::M_IND_DIR, 0, 2, 2);
    run(itt_pkg::C_DATA_POINTER_LOAD, itt_pkg::M_IMM, 0, 3, 3);
  endtask

  task automatic t_xfer;
    run(itt_pkg::C_CODE_MOVE, itt_pkg::M_PC, 0, 1, 3);
    run(itt_pkg::C_CODE_MOVE, itt_pkg::M_DATA_POINTER, 0, 1, 3);
    run(itt_pkg::C_XMOVE_RD, itt_pkg::M_IND, 0, 1, 3);
    run(itt_pkg::C_XMOVE_RD, itt_pkg::M_DATA_POINTER, 0, 1, 3);
    run(itt_pkg::C_XMOVE_WR, itt_pkg::M_DATA_POINTER, 0, 1, 3);
    run(itt_pkg::C_XMOVE_WR, itt_pkg::M_IND, 0, 1, 3);
    run(itt_pkg::C_POP, itt_pkg::M_DIR, 0, 2, 2);
    run(itt_pkg::C_PUSH, itt_pkg::M_DIR, 0, 2, 2);
    run(itt_pkg::C_XCH, itt_pkg::M_REG, 0, 1, 1);
    run(itt_pkg::C_XCH, itt_pkg::M_DIR, 0, 2, 2);
    run(itt_pkg::C_XCH, itt_pkg::M_IND, 0, 1, 2);
    run(itt_pkg::C_LOW_NIBBLE_EXCHANGE, itt_pkg::M_IND, 0, 1, 2);
    run(itt_pkg::C_OTHER, itt_pkg::M_ACC, 0, 0, 0);
  endtask

  task automatic t_branch;
    run(itt_pkg::C_BRANCH, itt_pkg::M_REG, 1, 2, 3);
    run(itt_pkg::C_BRANCH, itt_pkg::M_REG, 0, 2, 2);
    run(itt_pkg::C_BRANCH, itt_pkg::M_DIR, 1, 3, 4);
    run(itt_pkg::C_BRANCH, itt_pkg::M_DIR, 0, 3, 3);
    run(itt_pkg::C_BRANCH, itt_pkg::M_ACC, 0, 0, 0);
  endtask

  // writes steered by the store enable, reads stay in ram
  task automatic t_steer;
    xd_wr_req = 1'b1;
    for (int e = 0; e < 2; e++)
    begin
      xd_req = '{addr: 16'h3c00 | 16'(e), data: 8'h5a};
      prog_store_wr_en = e[0];
      @(negedge sys_clk);
      check("flash_wr", 24'(flash_wr), 24'(e));
      check("external_ram_wr", 24'(external_ram_wr), 24'(1 - e));
      check("mem_req", mem_req, xd_req);
    end
    xd_wr_req = 1'b0;
    xd_rd_req = 1'b1;
    @(negedge sys_clk);
    check("external_ram_rd", 24'(external_ram_rd), 24'h1);
    // a read beside a write is refused, the ram write strobe still rises
    xd_wr_req = 1'b1;
    prog_store_wr_en = 1'b0;
    @(negedge sys_clk);
    xd_wr_req = 1'b0;
    xd_rd_req = 1'b0;
    check("external_ram_rd", 24'(external_ram_rd), 24'h0);
    check("external_ram_wr", 24'(external_ram_wr), 24'h1);
    check("flash_q", 24'(store.flash_q[16'h3c01]), 24'h5a);
    check("ram_q", 24'(store.ram_q[16'h3c00]), 24'h5a);
  endtask

  initial
  begin
    repeat (5) @(negedge sys_clk);
    resetn = 1'b1;
    t_arith;
    t_logic;
    t_move;
    t_xfer;
    t_branch;
    t_steer;
    summarize;
  end

  // watchdog, well beyond the roughly 150 cycles of tests
  initial
  begin
    #40000;
    err_count++;
    summarize;
  end
endmodule

bind itt_core itt_core_chk u_chk (.sys_clk, .resetn, .instr_valid, .instr,
  .branch_taken, .instr_ready, .instr_busy, .instr_done, .instr_cycles,
  .xd_wr_req, .xd_rd_req, .xd_req, .prog_store_wr_en, .external_ram_wr, .external_ram_rd,
  .flash_wr, .mem_req);
